// ### design/ssc_pkg.sv
// Constants shared by the switch port statistics counter bank.
// Assumes one core clock; all counter events come from MAC logic on that clock.
//
// Behaviour
// - Thirty-two statistics counters kept per switch port.
// - Bit 31 overflow flag, bit 30 valid flag.
// - Thirty-bit count, cleared to zero when read.
// - First port counters at indirect 0x00-0x1F.
// - Second port at 0x20-0x3F, same offsets.
// - Command starts read; data split high/low words.
// - Offset 0x0 adds received low-priority octets.
// - Offsets 0x2, 0x3 count undersize and fragments.
// - Offsets 0x4, 0x5 count oversize good, bad.
// - Offsets 0x6-0x8 count symbol, check, alignment errors.
// - Offsets 0x9, 0xA count control, pause frames.
// - Offsets 0xB-0xD count good rx broadcast/multicast/unicast.
// - Offsets 0xE-0x13 count received packets by length.
// - Offset 0x14 tx octets; 0x17 tx pause.
// - Offset 0x16 counts late collisions.
// - Offsets 0x18-0x1A count good tx broadcast/multicast/unicast.
// - Offsets 0x1B-0x1D count deferred, collisions, abandoned.
// - Offsets 0x1E, 0x1F count one/many collision sends.
// - Drop counters are 16 bits, no flags.
// - Drop counters at 0x100, 0x101, 0x103, 0x104.
// - Reading a drop counter leaves it unchanged.

package ssc_pkg;

	// ****************************************************************
	// Widths.
	// ****************************************************************
	localparam int SSC_DATA_W = 16;
	localparam int SSC_ADDR_W = 8;
	localparam int SSC_IADDR_W = 10;
	localparam int SSC_CNT_W = 30;
	localparam int SSC_DROP_W = 16;
	localparam int SSC_LEN_W = 11;
	localparam int SSC_PORT_SPAN = 32;
	localparam int SSC_NUM_PORTS = 2;
	localparam int SSC_NUM_DROP = 4;

	// ****************************************************************
	// Register offsets and command fields.
	// ****************************************************************
	localparam logic [SSC_ADDR_W-1:0] SSC_REG_CMD = 8'h00;
	localparam logic [SSC_ADDR_W-1:0] SSC_REG_LOW = 8'h08;
	localparam logic [SSC_ADDR_W-1:0] SSC_REG_HIGH = 8'h0a;
	localparam int SSC_CMD_RD_BIT = 12;
	localparam int SSC_CMD_TBL_HI = 11;
	localparam int SSC_CMD_TBL_LO = 10;
	localparam logic [1:0] SSC_TBL_STAT = 2'b11;
	localparam int SSC_OVF_BIT = 15;
	localparam int SSC_VALID_BIT = 14;
	localparam logic [SSC_DATA_W-1:0] SSC_WORD_RST = 16'h0000;

	// ****************************************************************
	// Indirect addresses.
	// ****************************************************************
	localparam logic [SSC_IADDR_W-1:0] SSC_P1_BASE = 10'h000;
	localparam logic [SSC_IADDR_W-1:0] SSC_P2_BASE = 10'h020;
	localparam logic [SSC_IADDR_W-1:0] SSC_PORT_END = 10'h03f;
	localparam logic [SSC_IADDR_W-1:0] SSC_DROP_TX1 = 10'h100;
	localparam logic [SSC_IADDR_W-1:0] SSC_DROP_TX2 = 10'h101;
	localparam logic [SSC_IADDR_W-1:0] SSC_DROP_RX1 = 10'h103;
	localparam logic [SSC_IADDR_W-1:0] SSC_DROP_RX2 = 10'h104;

	// ****************************************************************
	// Per-port counter offsets.
	// ****************************************************************
	localparam logic [4:0] SSC_OFF_RX_OCTETS = 5'h00;
	localparam logic [4:0] SSC_OFF_RESV_RX = 5'h01;
	localparam logic [4:0] SSC_OFF_RX_TOO_SHORT = 5'h02;
	localparam logic [4:0] SSC_OFF_RX_FRAGMENT = 5'h03;
	localparam logic [4:0] SSC_OFF_RX_LONG_GOOD = 5'h04;
	localparam logic [4:0] SSC_OFF_RX_LONG_BAD = 5'h05;
	localparam logic [4:0] SSC_OFF_RX_BAD_SYMBOL = 5'h06;
	localparam logic [4:0] SSC_OFF_RX_MISALIGNED = 5'h08;
	localparam logic [4:0] SSC_OFF_RX_PAUSE = 5'h0a;
	localparam logic [4:0] SSC_OFF_RX_UNICAST = 5'h0d;
	localparam logic [4:0] SSC_OFF_RX_LEN_MIN = 5'h0e;
	localparam logic [4:0] SSC_OFF_RX_LEN_MAX = 5'h13;
	localparam logic [4:0] SSC_OFF_TX_OCTETS = 5'h14;
	localparam logic [4:0] SSC_OFF_RESV_TX = 5'h15;
	localparam logic [4:0] SSC_OFF_TX_LATE = 5'h16;
	localparam logic [4:0] SSC_OFF_TX_PAUSE = 5'h17;
	localparam logic [4:0] SSC_OFF_TX_UNICAST = 5'h1a;
	localparam logic [4:0] SSC_OFF_TX_POSTPONED = 5'h1b;
	localparam logic [4:0] SSC_OFF_TX_ABANDONED = 5'h1d;
	localparam logic [4:0] SSC_OFF_TX_ONE_COLL = 5'h1e;
	localparam logic [4:0] SSC_OFF_TX_MANY_COLL = 5'h1f;

	typedef logic [SSC_IADDR_W-1:0] ssc_iaddr_t;

endpackage : ssc_pkg

// ### design/ssc_count_cell.sv
// One event counter with a sticky overflow flag and a clear input.
// Assumes increment and clear come from logic on the same clock.
`timescale 1ns/10ps

module ssc_count_cell #(
	parameter int W = 30,
	parameter int AW = 11
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic [AW-1:0] inc_i,
	input wire logic clr_i,
	output logic [W-1:0] val_o,
	output logic ovf_o
);

	logic [W-1:0] val_q, val_d;
	logic ovf_q, ovf_d;
	logic [W:0] sum;

	// A clear in the cycle of an event restarts from that event, so no event is lost.
	always_comb begin
		sum = (clr_i ? {(W+1){1'b0}} : {1'b0, val_q}) + (W+1)'(inc_i);
		val_d = sum[W-1:0];
		ovf_d = (clr_i ? 1'b0 : ovf_q) | sum[W];
	end

	// Count and flag registers.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			val_q <= '0;
			ovf_q <= 1'b0;
		end else begin
			val_q <= val_d;
			ovf_q <= ovf_d;
		end
	end

	assign val_o = val_q;
	assign ovf_o = ovf_q;

endmodule : ssc_count_cell

// ### design/ssc_stat_bank.sv
// Statistics counter bank for two switch ports plus shared drop counters.
// Assumes MAC event pulses and the register port run on ref_clk_i.
`timescale 1ns/10ps

module ssc_stat_bank
	import ssc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic [ssc_pkg::SSC_ADDR_W-1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [ssc_pkg::SSC_DATA_W-1:0] reg_wdata_i,
	output logic [ssc_pkg::SSC_DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic [ssc_pkg::SSC_PORT_SPAN-1:0] p1_event_i,
	input wire logic [ssc_pkg::SSC_LEN_W-1:0] p1_rx_len_i,
	input wire logic [ssc_pkg::SSC_LEN_W-1:0] p1_tx_len_i,
	input wire logic [ssc_pkg::SSC_PORT_SPAN-1:0] p2_event_i,
	input wire logic [ssc_pkg::SSC_LEN_W-1:0] p2_rx_len_i,
	input wire logic [ssc_pkg::SSC_LEN_W-1:0] p2_tx_len_i,
	input wire logic [ssc_pkg::SSC_NUM_DROP-1:0] drop_event_i
);
	import ssc_pkg::*;

	localparam int NCNT = SSC_NUM_PORTS * SSC_PORT_SPAN;

	// ****************************************************************
	// Helper functions.
	// ****************************************************************

	// Amount added to a per-port counter for one event bit.
	function automatic logic [SSC_LEN_W-1:0] evt_amount(input logic [4:0] off,
			input logic evt, input logic [SSC_LEN_W-1:0] rx_len,
			input logic [SSC_LEN_W-1:0] tx_len);
		logic [SSC_LEN_W-1:0] amt;
		amt = {{(SSC_LEN_W-1){1'b0}}, evt};
		if (off == SSC_OFF_RX_OCTETS) begin
			amt = evt ? rx_len : '0;
		end else if (off == SSC_OFF_TX_OCTETS) begin
			amt = evt ? tx_len : '0;
		end else if (off == SSC_OFF_RESV_RX || off == SSC_OFF_RESV_TX) begin
			amt = '0;
		end
		return amt;
	endfunction : evt_amount

	// Maps an indirect address to a per-port counter index.
	function automatic logic [6:0] port_sel(input ssc_iaddr_t a);
		return {(a <= SSC_PORT_END), a[5:0]};
	endfunction : port_sel

	// Maps an indirect address to a drop counter index.
	function automatic logic [2:0] drop_sel(input ssc_iaddr_t a);
		logic [2:0] s;
		s = 3'b000;
		if (a == SSC_DROP_TX1) begin
			s = 3'b100;
		end else if (a == SSC_DROP_TX2) begin
			s = 3'b101;
		end else if (a == SSC_DROP_RX1) begin
			s = 3'b110;
		end else if (a == SSC_DROP_RX2) begin
			s = 3'b111;
		end
		return s;
	endfunction : drop_sel

	// ****************************************************************
	// Counter storage.
	// ****************************************************************
	logic [SSC_PORT_SPAN-1:0] ev_w [SSC_NUM_PORTS];
	logic [SSC_LEN_W-1:0] rx_len_w [SSC_NUM_PORTS];
	logic [SSC_LEN_W-1:0] tx_len_w [SSC_NUM_PORTS];
	logic [SSC_CNT_W-1:0] cnt_w [NCNT];
	logic ovf_w [NCNT];
	logic [SSC_LEN_W-1:0] inc_w [NCNT];
	logic clr_w [NCNT];
	logic [SSC_DROP_W-1:0] drop_w [SSC_NUM_DROP];

	// Per-port inputs gathered so one loop serves both ports.
	assign ev_w[0] = p1_event_i;
	assign ev_w[1] = p2_event_i;
	assign rx_len_w[0] = p1_rx_len_i;
	assign rx_len_w[1] = p2_rx_len_i;
	assign tx_len_w[0] = p1_tx_len_i;
	assign tx_len_w[1] = p2_tx_len_i;

	// Command, capture and read state.
	logic [SSC_DATA_W-1:0] cmd_q, cmd_d;
	logic pend_q, pend_d;
	logic [SSC_DATA_W-1:0] high_q, high_d;
	logic [SSC_DATA_W-1:0] low_q, low_d;
	logic [SSC_DATA_W-1:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic [6:0] psel_w;
	logic [2:0] dsel_w;
	logic port_hit_w, drop_hit_w, new_cmd_w, cmd_read_w;
	logic [5:0] cap_idx_w;
	logic [1:0] drop_idx_w;
	logic [2*SSC_DATA_W-1:0] cap_word_w;
	logic [SSC_DROP_W-1:0] drop_val_w;

	// Decode of the latched command address.
	assign psel_w = port_sel(cmd_q[SSC_IADDR_W-1:0]);
	assign dsel_w = drop_sel(cmd_q[SSC_IADDR_W-1:0]);
	assign port_hit_w = psel_w[6];
	assign drop_hit_w = dsel_w[2];
	assign cap_idx_w = psel_w[5:0];
	assign drop_idx_w = dsel_w[1:0];
	assign drop_val_w = drop_w[drop_idx_w];
	assign cap_word_w = {ovf_w[cap_idx_w], 1'b1, cnt_w[cap_idx_w]};
	assign new_cmd_w = reg_wr_i && (reg_addr_i == SSC_REG_CMD);
	assign cmd_read_w = reg_wdata_i[SSC_CMD_RD_BIT]
		&& (reg_wdata_i[SSC_CMD_TBL_HI:SSC_CMD_TBL_LO] == SSC_TBL_STAT);

	// One cell per per-port counter; the MAC classifies frames per offset bit.
	for (genvar i = 0; i < NCNT; i++) begin : g_port_cnt
		assign inc_w[i] = evt_amount(5'(i % SSC_PORT_SPAN), ev_w[i / SSC_PORT_SPAN][i % SSC_PORT_SPAN],
			rx_len_w[i / SSC_PORT_SPAN], tx_len_w[i / SSC_PORT_SPAN]);
		assign clr_w[i] = pend_q && port_hit_w && !new_cmd_w && (cap_idx_w == 6'(i));
		ssc_count_cell #(.W(SSC_CNT_W), .AW(SSC_LEN_W)) u_cell (
			.ref_clk_i(ref_clk_i),
			.rst_b_i(rst_b_i),
			.inc_i(inc_w[i]),
			.clr_i(clr_w[i]),
			.val_o(cnt_w[i]),
			.ovf_o(ovf_w[i])
		);
	end

	// Drop counters wrap silently and are never cleared by a read.
	for (genvar d = 0; d < SSC_NUM_DROP; d++) begin : g_drop_cnt
		ssc_count_cell #(.W(SSC_DROP_W), .AW(1)) u_cell (
			.ref_clk_i(ref_clk_i),
			.rst_b_i(rst_b_i),
			.inc_i(drop_event_i[d]),
			.clr_i(1'b0),
			.val_o(drop_w[d]),
			.ovf_o()
		);
	end

	// ****************************************************************
	// Indirect command and data registers.
	// ****************************************************************

	// Capture runs one cycle after the command, so the high word shows
	// valid low for that cycle; a new command aborts any capture in flight.
	always_comb begin
		cmd_d = cmd_q;
		pend_d = 1'b0;
		high_d = high_q;
		low_d = low_q;
		if (pend_q && !new_cmd_w) begin
			if (port_hit_w) begin
				high_d = cap_word_w[2*SSC_DATA_W-1:SSC_DATA_W];
				low_d = cap_word_w[SSC_DATA_W-1:0];
			end else if (drop_hit_w) begin
				high_d = SSC_WORD_RST;
				low_d = drop_val_w;
			end else begin
				high_d = SSC_WORD_RST;
				low_d = SSC_WORD_RST;
			end
		end
		if (new_cmd_w) begin
			cmd_d = reg_wdata_i;
			pend_d = cmd_read_w;
			if (cmd_read_w) begin
				high_d = SSC_WORD_RST;
				low_d = SSC_WORD_RST;
			end
		end
	end

	// Read port: data stands until the next read.
	always_comb begin
		rdata_d = rdata_q;
		rvalid_d = reg_rd_i;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				SSC_REG_CMD: rdata_d = cmd_q;
				SSC_REG_LOW: rdata_d = low_q;
				SSC_REG_HIGH: rdata_d = high_q;
				default: rdata_d = SSC_WORD_RST;
			endcase
		end
	end

	// Register stage for command, data words and read answer.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_q <= SSC_WORD_RST;
			pend_q <= 1'b0;
			high_q <= SSC_WORD_RST;
			low_q <= SSC_WORD_RST;
			rdata_q <= SSC_WORD_RST;
			rvalid_q <= 1'b0;
		end else begin
			cmd_q <= cmd_d;
			pend_q <= pend_d;
			high_q <= high_d;
			low_q <= low_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign reg_rvalid_o = rvalid_q;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	logic [SSC_CNT_W-1:0] p1_oct_w, p1_bin_w, p2_bin_w, p1_resv_w;
	logic p1_bin_ovf_w;
	assign p1_oct_w = cnt_w[SSC_OFF_RX_OCTETS];
	assign p1_bin_w = cnt_w[SSC_OFF_RX_LEN_MIN];
	assign p1_bin_ovf_w = ovf_w[SSC_OFF_RX_LEN_MIN];
	assign p2_bin_w = cnt_w[SSC_PORT_SPAN + SSC_OFF_RX_LEN_MIN];
	assign p1_resv_w = cnt_w[SSC_OFF_RESV_RX];

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_cmd_read;
		new_cmd_w && cmd_read_w;
	endsequence
	sequence s_port_capture;
		pend_q && port_hit_w && !new_cmd_w;
	endsequence
	sequence s_drop_capture;
		pend_q && drop_hit_w && !new_cmd_w;
	endsequence

	property p_valid_low_then_high;
		s_cmd_read ##1 s_port_capture |=> high_q[SSC_VALID_BIT];
	endproperty
	a_valid_low_then_high: assert property (p_valid_low_then_high)
		else $error("valid flag not set after capture");

	property p_pending_hides_valid;
		s_cmd_read |=> !high_q[SSC_VALID_BIT] && pend_q;
	endproperty
	a_pending_hides_valid: assert property (p_pending_hides_valid)
		else $error("valid flag seen before capture");

	property p_capture_word;
		s_port_capture |=> {high_q, low_q} == $past(cap_word_w);
	endproperty
	a_capture_word: assert property (p_capture_word)
		else $error("captured word differs from counter");

	property p_clear_on_read;
		pend_q && port_hit_w && !new_cmd_w && inc_w[cap_idx_w] == '0
			|=> cnt_w[$past(cap_idx_w)] == '0 && !ovf_w[$past(cap_idx_w)];
	endproperty
	a_clear_on_read: assert property (p_clear_on_read)
		else $error("counter or flag not cleared by read");

	property p_drop_keep;
		pend_q && drop_hit_w && drop_event_i == '0 |=> drop_w[$past(drop_idx_w)] == $past(drop_val_w);
	endproperty
	a_drop_keep: assert property (p_drop_keep)
		else $error("drop counter changed by read");

	property p_drop_no_flags;
		s_drop_capture |=> high_q == SSC_WORD_RST && low_q == $past(drop_val_w);
	endproperty
	a_drop_no_flags: assert property (p_drop_no_flags)
		else $error("drop counter word wrong");

	property p_rx_octets;
		p1_event_i[SSC_OFF_RX_OCTETS] && !clr_w[SSC_OFF_RX_OCTETS]
			|=> p1_oct_w == SSC_CNT_W'($past(p1_oct_w) + $past(p1_rx_len_i));
	endproperty
	a_rx_octets: assert property (p_rx_octets)
		else $error("octet counter did not add length");

	property p_p1_bin;
		p1_event_i[SSC_OFF_RX_LEN_MIN] && !clr_w[SSC_OFF_RX_LEN_MIN]
			|=> p1_bin_w == SSC_CNT_W'($past(p1_bin_w) + 1);
	endproperty
	a_p1_bin: assert property (p_p1_bin)
		else $error("first port length bin did not count");

	property p_p2_bin;
		p2_event_i[SSC_OFF_RX_LEN_MIN] && !clr_w[SSC_PORT_SPAN + SSC_OFF_RX_LEN_MIN]
			|=> p2_bin_w == SSC_CNT_W'($past(p2_bin_w) + 1);
	endproperty
	a_p2_bin: assert property (p_p2_bin)
		else $error("second port length bin did not count");

	property p_overflow;
		p1_bin_w == '1 && p1_event_i[SSC_OFF_RX_LEN_MIN] && !clr_w[SSC_OFF_RX_LEN_MIN]
			|=> p1_bin_ovf_w && p1_bin_w == '0;
	endproperty
	a_overflow: assert property (p_overflow)
		else $error("overflow flag not set on wrap");

	property p_reserved_idle;
		p1_resv_w == '0 |=> p1_resv_w == '0;
	endproperty
	a_reserved_idle: assert property (p_reserved_idle)
		else $error("reserved counter moved");

	property p_read_high;
		reg_rd_i && reg_addr_i == SSC_REG_HIGH |=> reg_rvalid_o && reg_rdata_o == $past(high_q);
	endproperty
	a_read_high: assert property (p_read_high)
		else $error("high data read wrong");

endmodule : ssc_stat_bank

// ### test/ssc_stat_bank_tb.sv
// Self-checking testbench for the switch port statistics counter bank.
// Assumes ssc_pkg is compiled first; drives all inputs at the falling clock edge.
`timescale 1ns/10ps

module ssc_stat_bank_tb;
	import ssc_pkg::*;

	// ****************************************************************
	// Stimulus signals and bookkeeping.
	// ****************************************************************
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [SSC_ADDR_W-1:0] reg_addr_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [SSC_DATA_W-1:0] reg_wdata_i = 16'h0000;
	logic [SSC_DATA_W-1:0] reg_rdata_o;
	logic reg_rvalid_o;
	logic [SSC_PORT_SPAN-1:0] p1_event_i = 32'h0000_0000;
	logic [SSC_PORT_SPAN-1:0] p2_event_i = 32'h0000_0000;
	logic [SSC_LEN_W-1:0] p1_rx_len_i = 11'h064;
	logic [SSC_LEN_W-1:0] p1_tx_len_i = 11'h032;
	logic [SSC_LEN_W-1:0] p2_rx_len_i = 11'h12c;
	logic [SSC_LEN_W-1:0] p2_tx_len_i = 11'h046;
	logic [SSC_NUM_DROP-1:0] drop_event_i = 4'h0;
	int n_mismatch = 0;
	int check_count = 0;

	// Free-running core clock, 100 ns period.
	always #50 ref_clk_i = ~ref_clk_i;

	ssc_stat_bank dut (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o),
		.p1_event_i(p1_event_i),
		.p1_rx_len_i(p1_rx_len_i),
		.p1_tx_len_i(p1_tx_len_i),
		.p2_event_i(p2_event_i),
		.p2_rx_len_i(p2_rx_len_i),
		.p2_tx_len_i(p2_tx_len_i),
		.drop_event_i(drop_event_i)
	);

	// ****************************************************************
	// Access tasks.
	// ****************************************************************
	// Compares one word and reports a mismatch at once.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	// Each task that raises a strobe ends with an idle cycle so no strobe is raised and lowered in one step.
	task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge ref_clk_i);
		reg_wr_i = 1'b0;
		@(negedge ref_clk_i);
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge ref_clk_i);
		reg_rd_i = 1'b0;
		chk({15'h0000, reg_rvalid_o}, 16'h0001, "read answer missing");
		d = reg_rdata_o;
		@(negedge ref_clk_i);
	endtask : reg_read

	// Starts a counter read, then takes the high word (retried up to four times while not valid) and the low.
	task automatic rd_ctr(input logic [9:0] ia, output logic [15:0] hi, output logic [15:0] lo);
		int tries;
		tries = 0;
		reg_write(SSC_REG_CMD, 16'h1c00 | {6'h00, ia});
		reg_read(SSC_REG_HIGH, hi);
		while (hi[SSC_VALID_BIT] !== 1'b1 && tries < 4) begin
			reg_read(SSC_REG_HIGH, hi);
			tries++;
		end
		reg_read(SSC_REG_LOW, lo);
	endtask : rd_ctr

	// Pulses one event bit n times; port 2 means the shared drop inputs.
	task automatic pulse(input int port, input int bitn, input int n);
		repeat (n) begin
			if (port == 0) begin
				p1_event_i = 32'h0000_0001 << bitn;
			end else if (port == 1) begin
				p2_event_i = 32'h0000_0001 << bitn;
			end else begin
				drop_event_i = 4'h1 << bitn;
			end
			@(negedge ref_clk_i);
			p1_event_i = 32'h0000_0000;
			p2_event_i = 32'h0000_0000;
			drop_event_i = 4'h0;
			@(negedge ref_clk_i);
		end
	endtask : pulse

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	// ****************************************************************
	// Test sequence.
	// ****************************************************************
	initial begin
		logic [15:0] hi;
		logic [15:0] lo;
		logic [15:0] mask;
		logic [29:0] e;
		logic [9:0] drop_addr [4];
		int n;
		drop_addr = '{SSC_DROP_TX1, SSC_DROP_TX2, SSC_DROP_RX1, SSC_DROP_RX2};
		repeat (5) @(negedge ref_clk_i);
		rst_b_i = 1'b1;
		@(negedge ref_clk_i);
		reg_read(SSC_REG_HIGH, hi);
		chk(hi, 16'h0000, "high word after reset");
		reg_read(SSC_REG_LOW, lo);
		chk(lo, 16'h0000, "low word after reset");
		$display("test reset done");
		// Each counter gets one to three event pulses set by its offset; the other port stays untouched until its turn.
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 32; k++) begin
				n = k % 3 + 1;
				pulse(p, k, n);
				e = 30'(n);
				if (k == 0) begin
					e = 30'(n * ((p == 0) ? p1_rx_len_i : p2_rx_len_i));
				end else if (k == 20) begin
					e = 30'(n * ((p == 0) ? p1_tx_len_i : p2_tx_len_i));
				end else if (k == 1 || k == 21) begin
					e = 30'h0000_0000;
				end
				// Reserved offsets have no documented flag meaning, so only their count is compared.
				mask = (k == 1 || k == 21) ? 16'h3fff : 16'hffff;
				rd_ctr(10'(p * 32 + k), hi, lo);
				chk(hi & mask, {2'b01, e[29:16]} & mask, "counter high");
				chk(lo, e[15:0], "counter low");
				rd_ctr(10'(p * 32 + k), hi, lo);
				chk(hi & mask, 16'h4000 & mask, "high after clear");
				chk(lo, 16'h0000, "low after clear");
			end
		end
		$display("test per-port counters done");
		for (int d = 0; d < 4; d++) begin
			pulse(2, d, d + 2);
			repeat (2) begin
				rd_ctr(drop_addr[d], hi, lo);
				chk(hi, 16'h0000, "drop high word");
				chk(lo, 16'(d + 2), "drop count");
			end
		end
		$display("test drop counters done");
		rd_ctr(10'h040, hi, lo);
		chk(hi, 16'h0000, "unmapped indirect high");
		chk(lo, 16'h0000, "unmapped indirect low");
		reg_write(SSC_REG_LOW, 16'hffff);
		reg_read(SSC_REG_LOW, lo);
		chk(lo, 16'h0000, "low data write ignored");
		reg_read(8'h04, lo);
		chk(lo, 16'h0000, "unmapped register");
		$display("test refusals done");
		// A high-word read one edge after the command lands before the capture completes.
		pulse(0, SSC_OFF_RX_LEN_MIN, 2);
		reg_addr_i = SSC_REG_CMD;
		reg_wdata_i = 16'h1c0e;
		reg_wr_i = 1'b1;
		@(negedge ref_clk_i);
		reg_wr_i = 1'b0;
		reg_addr_i = SSC_REG_HIGH;
		reg_rd_i = 1'b1;
		@(negedge ref_clk_i);
		reg_rd_i = 1'b0;
		chk({15'h0000, reg_rvalid_o}, 16'h0001, "pending read answer missing");
		chk(reg_rdata_o, 16'h0000, "high word while capture pending");
		@(negedge ref_clk_i);
		reg_read(SSC_REG_HIGH, hi);
		chk(hi, 16'h4000, "high word after capture");
		reg_read(SSC_REG_LOW, lo);
		chk(lo, 16'h0002, "low word after capture");
		// A command without the read bit is only stored and leaves the data words alone.
		reg_write(SSC_REG_CMD, 16'h0c05);
		reg_read(SSC_REG_CMD, lo);
		chk(lo, 16'h0c05, "stored command");
		reg_read(SSC_REG_LOW, lo);
		chk(lo, 16'h0002, "low word kept by other command");
		$display("test pending read done");
		wrap_up();
	end

	// Cuts a hang short well beyond the little over a thousand cycles the tests need.
	initial begin
		repeat (30000) @(posedge ref_clk_i);
		n_mismatch++;
		$display("unexpected at %0t: watchdog expired", $time);
		wrap_up();
	end

endmodule : ssc_stat_bank_tb
